/* rtl/ddsc_cfg.svh */
// Constants of the dual DAC serial command decoder.
// Assumes inclusion by its bare name from the package.
`ifndef DDSC_CFG_SVH
`define DDSC_CFG_SVH
`define DDSC_WORD_BITS 16
`define DDSC_CMD_MSB 15
`define DDSC_CMD_LSB 12
`define DDSC_CODE_MSB 11
`define DDSC_CODE_LSB 2
`define DDSC_TERM_MSB 1
`define DDSC_TERM_LSB 0
`define DDSC_SEL_MSB 4
`define DDSC_SEL_LSB 2
`define DDSC_DISCARD_BITS 5'h0F
`define DDSC_FULL_BITS 5'h10
`define DDSC_CMD_WR_A 4'h0
`define DDSC_CMD_WR_B 4'h1
`define DDSC_CMD_LD_A 4'h4
`define DDSC_CMD_LD_B 4'h5
`define DDSC_CMD_UP_A 4'h8
`define DDSC_CMD_UP_B 4'h9
`define DDSC_CMD_WR_AB 4'hC
`define DDSC_CMD_LD_AB 4'hD
`define DDSC_CMD_UP_AB 4'hE
`define DDSC_CMD_PWR 4'hF
`define DDSC_SEL_A 3'h0
`define DDSC_SEL_B 3'h1
`define DDSC_SEL_AB 3'h4
`define DDSC_CODE_RST 10'h000
`define DDSC_TERM_RST 2'h3
`define DDSC_IDLE_NS 80
`define DDSC_CLK_NS 40
`define DDSC_IDLE_CYC ((`DDSC_IDLE_NS + `DDSC_CLK_NS - 1) / `DDSC_CLK_NS)
`endif

/* rtl/ddsc_pkg.sv */
// Types of the dual DAC serial command decoder.
// Assumes ddsc_cfg.svh is on the include path.
`include "ddsc_cfg.svh"
package ddsc_pkg;
  typedef struct packed {
    logic [3:0] command_code;
    logic [9:0] sample_code;
    logic [1:0] termination_select;
  } ddsc_word_t;
  typedef struct packed {
    logic [9:0] channel_a_output;
    logic [9:0] channel_b_output;
    logic [1:0] term_a;
    logic [1:0] term_b;
  } ddsc_state_t;
  typedef enum logic [1:0] {
    DDSC_IDLE = 2'h0,
    DDSC_SYNC = 2'h1,
    DDSC_EXEC = 2'h3
  } ddsc_fsm_t;
endpackage : ddsc_pkg

/* rtl/ddsc_shift.sv */
// Link-side shifter: samples data on falling serial clock edges.
// Assumes the serial clock stops outside frames; frame chip select
// resets the bit count asynchronously, a constant load only; srst
// clears the word toggle and is released only while sclk is idle.
`timescale 1ns/1ps
module ddsc_shift
  import ddsc_pkg::*;
(
  input wire logic sclk,
  input wire logic srst,
  input wire logic cs_n,
  input wire logic din,
  output logic [15:0] word_q,
  output logic done_tgl_q
);
  logic [4:0] cnt_q;

  // Chip select high clears the count, discarding short words
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      cnt_q <= 5'h00;
    end else if (cnt_q != `DDSC_FULL_BITS) begin
      cnt_q <= cnt_q + 5'h01;
    end
  end

  always_ff @(negedge sclk) begin
    if (!cs_n && cnt_q != `DDSC_FULL_BITS) begin
      word_q <= {word_q[14:0], din};
    end
  end

  // Toggle on the sixteenth bit so one word crosses as one event;
  // a toggle survives a frozen clk side, a level would be lost
  always_ff @(negedge sclk or posedge srst) begin
    if (srst) begin
      done_tgl_q <= 1'b0;
    end else if (!cs_n && cnt_q == `DDSC_DISCARD_BITS) begin
      done_tgl_q <= ~done_tgl_q;
    end
  end
endmodule : ddsc_shift

/* rtl/ddsc_decoder.sv */
// Dual 10-bit DAC command decoder: serial word in, DAC state out.
// Assumes clk at 25 MHz; sclk, cs_n and din come from the host pins.
`timescale 1ns/1ps
module ddsc_decoder
  import ddsc_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic [9:0] channel_a_output_q,
  output logic [9:0] channel_b_output_q,
  output logic [9:0] input_a_q,
  output logic [9:0] input_b_q,
  output logic [1:0] term_a_q,
  output logic [1:0] term_b_q,
  output logic powered_a_q,
  output logic powered_b_q,
  output logic word_done_q
);
  logic [15:0] link_word;
  logic link_tgl;
  logic [2:0] tgl_sync_q;
  logic [15:0] word_hold_q;
  ddsc_word_t cmd;
  ddsc_fsm_t state_q;
  logic [2:0] sel;

  ddsc_shift u_shift (
    .sclk(sclk),
    .srst(srst),
    .cs_n(cs_n),
    .din(din),
    .word_q(link_word),
    .done_tgl_q(link_tgl)
  );

  // Word is stable from the toggle until the next frame's bits;
  // the host idle time covers the sync delay before capture
  always_ff @(posedge clk) begin
    if (srst) begin
      tgl_sync_q <= 3'h0;
    end else if (clk_en) begin
      tgl_sync_q <= {tgl_sync_q[1:0], link_tgl};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= DDSC_IDLE;
    end else if (clk_en) begin
      unique case (state_q)
        DDSC_IDLE: begin
          if (tgl_sync_q[2] != tgl_sync_q[1]) begin
            state_q <= DDSC_SYNC;
          end
        end
        DDSC_SYNC: state_q <= DDSC_EXEC;
        DDSC_EXEC: state_q <= DDSC_IDLE;
        default: state_q <= DDSC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      word_hold_q <= 16'h0000;
    end else if (clk_en && state_q == DDSC_SYNC) begin
      word_hold_q <= link_word;
    end
  end

  assign cmd = ddsc_word_t'(word_hold_q);
  assign sel = word_hold_q[`DDSC_SEL_MSB:`DDSC_SEL_LSB];

  always_ff @(posedge clk) begin
    if (srst) begin
      word_done_q <= 1'b0;
    end else if (clk_en) begin
      word_done_q <= (state_q == DDSC_EXEC);
    end
  end

  // Input registers
  always_ff @(posedge clk) begin
    if (srst) begin
      input_a_q <= `DDSC_CODE_RST;
      input_b_q <= `DDSC_CODE_RST;
    end else if (clk_en && state_q == DDSC_EXEC) begin
      unique case (cmd.command_code)
        `DDSC_CMD_WR_A, `DDSC_CMD_LD_A: begin
          input_a_q <= cmd.sample_code;
        end
        `DDSC_CMD_WR_B, `DDSC_CMD_LD_B: begin
          input_b_q <= cmd.sample_code;
        end
        `DDSC_CMD_WR_AB, `DDSC_CMD_LD_AB: begin
          input_a_q <= cmd.sample_code;
          input_b_q <= cmd.sample_code;
        end
        default: begin
          input_a_q <= input_a_q;
        end
      endcase
    end
  end

  // DAC registers; power commands never touch them
  always_ff @(posedge clk) begin
    if (srst) begin
      channel_a_output_q <= `DDSC_CODE_RST;
      channel_b_output_q <= `DDSC_CODE_RST;
    end else if (clk_en && state_q == DDSC_EXEC) begin
      unique case (cmd.command_code)
        `DDSC_CMD_WR_A: channel_a_output_q <= cmd.sample_code;
        `DDSC_CMD_WR_B: channel_b_output_q <= cmd.sample_code;
        `DDSC_CMD_UP_A: channel_a_output_q <= input_a_q;
        `DDSC_CMD_UP_B: channel_b_output_q <= input_b_q;
        `DDSC_CMD_WR_AB: begin
          channel_a_output_q <= cmd.sample_code;
          channel_b_output_q <= cmd.sample_code;
        end
        `DDSC_CMD_UP_AB: begin
          channel_a_output_q <= input_a_q;
          channel_b_output_q <= input_b_q;
        end
        default: begin
          channel_a_output_q <= channel_a_output_q;
        end
      endcase
    end
  end

  // Termination: 00 awake, 01 float, 10 low load, 11 high load
  always_ff @(posedge clk) begin
    if (srst) begin
      term_a_q <= `DDSC_TERM_RST;
      term_b_q <= `DDSC_TERM_RST;
    end else if (clk_en && state_q == DDSC_EXEC &&
                 cmd.command_code == `DDSC_CMD_PWR) begin
      if (sel == `DDSC_SEL_A || sel == `DDSC_SEL_AB) begin
        term_a_q <= cmd.termination_select;
      end
      if (sel == `DDSC_SEL_B || sel == `DDSC_SEL_AB) begin
        term_b_q <= cmd.termination_select;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      powered_a_q <= 1'b0;
      powered_b_q <= 1'b0;
    end else if (clk_en) begin
      powered_a_q <= (term_a_q == 2'h0);
      powered_b_q <= (term_b_q == 2'h0);
    end
  end
endmodule : ddsc_decoder

/* tb/ddsc_host.sv */
// Host model driving the three-wire link.
// Assumes send is called from one process only.
`timescale 1ns/1ps
module ddsc_host (
  output logic sclk,
  output logic cs_n,
  output logic din
);
  // Late update gives the shifter a certain chip select rising edge
  initial {sclk, cs_n, din} <= 3'h2;
  // Clock stands still outside frames; data moves while it is low
  task send(input logic [15:0] w, input int n);
    cs_n = 0;
    #20;
    for (int i = 0; i < n; i++) begin
      din = i < 16 ? w[15 - i] : 1'b1;
      sclk = 1;
      #15 sclk = 0;
      #15;
    end
    din = ~din;
    #10 cs_n = 1;
    #400;
  endtask : send
endmodule : ddsc_host

/* tb/ddsc_decoder_monitor.sv */
// Checker of decoder output timing.
// Assumes it is bound into ddsc_decoder.
`timescale 1ns/1ps
module ddsc_decoder_monitor (
  input logic clk,
  input logic srst,
  input logic clk_en,
  input logic [9:0] channel_a_output_q,
  input logic [9:0] channel_b_output_q,
  input logic [1:0] term_a_q,
  input logic [1:0] term_b_q,
  input logic powered_a_q,
  input logic powered_b_q,
  input logic word_done_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Done pulse comes with every DAC or termination change; reset edges are excluded
  sequence s_done;
    word_done_q ##1 !word_done_q;
  endsequence
  a_reset_clear: assert property ($fell(srst) |->
    {channel_a_output_q, channel_b_output_q, term_a_q, term_b_q,
    powered_a_q, powered_b_q} == {20'h0, 6'h3C}) else $error("reset");
  a_dac_a_done: assert property (!$past(srst) &&
    $changed(channel_a_output_q) |-> s_done) else $error("dac a");
  a_dac_b_done: assert property (!$past(srst) &&
    $changed(channel_b_output_q) |-> s_done) else $error("dac b");
  a_term_done: assert property (!$past(srst) &&
    $changed({term_a_q, term_b_q}) |-> s_done) else $error("term");
  a_power_a_lag: assert property (clk_en |=>
    powered_a_q == ($past(term_a_q) == 2'h0)) else $error("power a");
  a_power_b_lag: assert property (clk_en |=>
    powered_b_q == ($past(term_b_q) == 2'h0)) else $error("power b");
  a_done_single: assert property (word_done_q |=>
    !word_done_q) else $error("done");
  a_freeze_hold: assert property (!clk_en |=> $stable({term_a_q,
    channel_a_output_q, channel_b_output_q})) else $error("freeze");
endmodule : ddsc_decoder_monitor
bind ddsc_decoder ddsc_decoder_monitor mon (
  .clk(clk),
  .srst(srst),
  .clk_en(clk_en),
  .channel_a_output_q(channel_a_output_q),
  .channel_b_output_q(channel_b_output_q),
  .term_a_q(term_a_q),
  .term_b_q(term_b_q),
  .powered_a_q(powered_a_q),
  .powered_b_q(powered_b_q),
  .word_done_q(word_done_q)
);

/* tb/tb_ddsc_decoder.sv */
// Bench: command words in, DAC state compared per row.
// Assumes the host model frames every word.
`timescale 1ns/1ps
module tb_ddsc_decoder;
  logic clk = 0, clk_en = 1;
  logic srst;
  wire sclk, cs_n, din;
  logic [9:0] a, b, ia, ib;
  logic [1:0] ta, tb;
  logic pa, pb;
  int fail_count = 0;
  int checked = 0;
  // Word, then expected {dac a, dac b, term a, term b}
  logic [39:0] rows [17] = '{40'h4554_00000F, 40'h5AA8_00000F,
    40'h8FFC_55400F, 40'h9FFC_556AAF, 40'hD3C0_556AAF,
    40'hE000_3C0F0F, 40'h0FFC_FFCF0F, 40'h1004_FFC01F,
    40'hC800_80200F, 40'hF001_802007, 40'hF006_802006,
    40'hF011_802005, 40'hF012_80200A, 40'hF013_80200F,
    40'hF010_802000, 40'hF007_802003, 40'hF008_802003};
  ddsc_decoder dut (.clk, .srst, .clk_en, .sclk, .cs_n, .din,
    .channel_a_output_q(a), .channel_b_output_q(b), .input_a_q(ia),
    .input_b_q(ib), .term_a_q(ta), .term_b_q(tb), .powered_a_q(pa),
    .powered_b_q(pb), .word_done_q());
  ddsc_host host (.sclk, .cs_n, .din);
  initial forever #20 clk = ~clk;
  task chk(input logic [63:0] s, e, input string n);
    @(negedge clk);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task final_report;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  initial begin
    #100000;
    fail_count++;
    final_report;
  end
  initial begin
    srst <= 1'b1;
    repeat (2) @(negedge clk);
    srst <= 1'b0;
    foreach (rows[i]) begin
      host.send(rows[i][39:24], 16);
      chk({a, b, ta, tb}, rows[i][23:0], "row");
      $display("row %0d done", i);
    end
    chk({ia, ib, pa, pb}, 22'h200802, "inputs");
    $display("inputs done");
    host.send(16'h0C04, 14);
    chk(a, 10'h200, "short");
    $display("short done");
    host.send(16'h1554, 18);
    chk(b, 10'h155, "extra");
    $display("extra done");
    clk_en = 0;
    host.send(16'h0554, 16);
    chk(a, 10'h200, "frozen");
    clk_en = 1;
    repeat (8) @(negedge clk);
    chk(a, 10'h155, "thawed");
    $display("freeze done");
    srst <= 1'b1;
    repeat (2) @(negedge clk);
    srst <= 1'b0;
    chk({a, b, ia, ib, ta, tb, pa, pb}, 46'h3C, "reset");
    $display("hand tests done");
    final_report;
  end
endmodule : tb_ddsc_decoder
